// ---- eeprom_cmd_pkg.sv ----
/*
 * constants for the serial eeprom command/protection block: opcodes,
 * status bit positions, array geometry and self-timed cycle durations.
 * assumes a 10 MHz system clock.
 */
package eeprom_cmd_pkg;
    localparam int CLK_HZ = 10_000_000;
    // opcodes
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_WRITE_UNLOCK = 8'h06;
    localparam logic [7:0] OP_WRITE_LOCK = 8'h04;
    localparam logic [7:0] OP_STATUS_READ = 8'h05;
    localparam logic [7:0] OP_PAGE_WIPE = 8'h42;
    localparam logic [7:0] OP_SECTOR_WIPE = 8'hd8;
    localparam logic [7:0] OP_CHIP_WIPE = 8'hc7;
    localparam logic [7:0] OP_DEEP_SLEEP = 8'hb9;
    localparam logic [7:0] OP_WAKE_SIG = 8'hab;
    // status bit positions
    localparam int SR_PIN_GUARD = 7;
    localparam int SR_GUARD_HIGH = 3;
    localparam int SR_GUARD_LOW = 2;
    localparam int SR_WEL = 1;
    localparam int SR_WIP = 0;
    localparam logic [7:0] SR_NV_MASK = 8'h8c;
    localparam logic [2:0] NV_RESET = 3'h0;
    // bit counts at which chip select must rise
    localparam logic [5:0] BITS_OPCODE = 6'h08;
    localparam logic [5:0] BITS_STATUS_WR = 6'h10;
    localparam logic [5:0] BITS_ADDR_CMD = 6'h20;
    // array geometry: 17-bit byte address, 256-byte page, 4 sectors
    localparam int ADDR_W = 17;
    localparam int PAGE_BITS = 8;
    // protected base address per block-guard setting
    localparam logic [16:0] PROT_QUARTER = 17'h18000;
    localparam logic [16:0] PROT_HALF = 17'h10000;
    // self-timed durations in microseconds
    localparam int T_STATUS_US = 6000;
    localparam int T_PAGE_US = 6000;
    localparam int T_SECTOR_US = 10000;
    localparam int T_CHIP_US = 10000;
    localparam int T_SLEEP_SETTLE_US = 3;
    localparam int T_WAKE_US = 100;
    localparam int CYC_PER_US = CLK_HZ / 1_000_000;
    localparam int CYC_STATUS = T_STATUS_US * CYC_PER_US;
    localparam int CYC_PAGE = T_PAGE_US * CYC_PER_US;
    localparam int CYC_SECTOR = T_SECTOR_US * CYC_PER_US;
    localparam int CYC_CHIP = T_CHIP_US * CYC_PER_US;
    localparam int CYC_SLEEP_SETTLE = T_SLEEP_SETTLE_US * CYC_PER_US;
    localparam int CYC_WAKE = T_WAKE_US * CYC_PER_US;
    localparam int SIG_W = 8;
endpackage : eeprom_cmd_pkg

// ---- sync_two_ff.sv ----
/*
 * two-flop level synchroniser for one asynchronous input.
 * assumes the input is a slow level relative to clock.
 */
`timescale 1ns/1ps
`default_nettype none
module sync_two_ff #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic asyncIn,
    output logic syncOut
);
    logic meta_ff;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= RESET_VAL;
            syncOut <= RESET_VAL;
        end else begin
            meta_ff <= asyncIn;
            syncOut <= meta_ff;
        end
    end
endmodule : sync_two_ff
`default_nettype wire

// ---- eeprom_protect_erase_powerdown.sv ----
/*
 * command-level logic of a serial eeprom: status write, block and pin
 * write guard, write-enable latch, page/sector/chip erase, deep sleep and
 * wake-with-signature. serial pins are sampled by the system clock.
 * assumes the serial clock is well below clock/4 and the array itself
 * lives outside, driven by the erase request ports; completion is self-timed.
 */
`timescale 1ns/1ps
`default_nettype none
module eeprom_protect_erase_powerdown
    import eeprom_cmd_pkg::*;
#(
    parameter int STATUS_CYCLES = CYC_STATUS,
    parameter int PAGE_CYCLES = CYC_PAGE,
    parameter int SECTOR_CYCLES = CYC_SECTOR,
    parameter int CHIP_CYCLES = CYC_CHIP,
    parameter int SETTLE_CYCLES = CYC_SLEEP_SETTLE,
    parameter int WAKE_CYCLES = CYC_WAKE,
    parameter logic [SIG_W-1:0] SIGNATURE = 8'h5a  // arbitrary value
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic chipSelN,
    input wire logic serialClk,
    input wire logic serialIn,
    input wire logic writeGuardN,
    output logic serialOut,
    output logic serialOutEnN,
    output logic [7:0] statusReg,
    output logic inDeepSleep,
    output logic sleepSettled,
    output logic wipeStart,
    output logic [1:0] wipeKind,
    output logic [ADDR_W-1:0] wipeAddr
);
    typedef enum {ST_IDLE, ST_OPCODE, ST_BODY, ST_SIGNATURE, ST_IGNORE} cmd_state_t;
    typedef enum {BZ_IDLE, BZ_BUSY} busy_state_t;
    localparam logic [1:0] KIND_PAGE = 2'h0;
    localparam logic [1:0] KIND_SECTOR = 2'h1;
    localparam logic [1:0] KIND_CHIP = 2'h2;
    localparam logic [1:0] KIND_STATUS = 2'h3;
    localparam int CNT_W = 24;

    logic csSync, sckSync, siSync, wpSync;
    sync_two_ff #(.RESET_VAL(1'b1)) uCs (.clock(clock), .rst_n(rst_n),
        .asyncIn(chipSelN), .syncOut(csSync));
    sync_two_ff #(.RESET_VAL(1'b0)) uSck (.clock(clock), .rst_n(rst_n),
        .asyncIn(serialClk), .syncOut(sckSync));
    sync_two_ff #(.RESET_VAL(1'b0)) uSi (.clock(clock), .rst_n(rst_n),
        .asyncIn(serialIn), .syncOut(siSync));
    sync_two_ff #(.RESET_VAL(1'b1)) uWp (.clock(clock), .rst_n(rst_n),
        .asyncIn(writeGuardN), .syncOut(wpSync));

    logic csPrev_ff, sckPrev_ff;
    logic csFall, csRise, sckRise, sckFall;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            csPrev_ff <= 1'b1;
            sckPrev_ff <= 1'b0;
        end else begin
            csPrev_ff <= csSync;
            sckPrev_ff <= sckSync;
        end
    end
    assign csFall = csPrev_ff & ~csSync;
    assign csRise = ~csPrev_ff & csSync;
    assign sckRise = ~csSync & sckSync & ~sckPrev_ff;
    assign sckFall = ~csSync & ~sckSync & sckPrev_ff;

    // nonvolatile bits; reset stands in for the stored value
    logic pinGuardEnable_ff;
    logic [1:0] blockGuard_ff;
    logic writeEnableLatch_ff;
    logic busy_ff;
    logic sleep_ff;
    cmd_state_t state_ff;
    busy_state_t busyState_ff;
    logic [5:0] bitCnt_ff;
    logic [7:0] opcode_ff;
    logic [CNT_W-1:0] shiftIn_ff;
    logic [2:0] sigBit_ff;
    logic [CNT_W-1:0] busyCnt_ff;
    logic [CNT_W-1:0] sleepCnt_ff;
    logic wakePending_ff;

    logic pinGuardActive;
    assign pinGuardActive = ~wpSync & pinGuardEnable_ff;

    // protected-range check for a target address
    function automatic logic addrGuarded(input logic [1:0] bg,
                                         input logic [ADDR_W-1:0] a);
        logic res;
        res = 1'b0;
        if (bg == 2'h1) begin
            res = (a >= PROT_QUARTER);
        end else if (bg == 2'h2) begin
            res = (a >= PROT_HALF);
        end else if (bg == 2'h3) begin
            res = 1'b1;
        end
        return res;
    endfunction : addrGuarded

    logic [ADDR_W-1:0] cmdAddr;
    assign cmdAddr = shiftIn_ff[ADDR_W-1:0];

    // decode what a deselect commits to, evaluated on csRise
    logic doUnlock, doLock, doStatus, doPage, doSector, doChip, doSleep;
    always_comb begin
        doUnlock = 1'b0;
        doLock = 1'b0;
        doStatus = 1'b0;
        doPage = 1'b0;
        doSector = 1'b0;
        doChip = 1'b0;
        doSleep = 1'b0;
        if (csRise && state_ff == ST_BODY && !busy_ff && !sleep_ff) begin
            if (opcode_ff == OP_WRITE_UNLOCK && bitCnt_ff == BITS_OPCODE) begin
                doUnlock = 1'b1;
            end else if (opcode_ff == OP_WRITE_LOCK && bitCnt_ff == BITS_OPCODE) begin
                doLock = 1'b1;
            end else if (opcode_ff == OP_STATUS_WRITE && bitCnt_ff == BITS_STATUS_WR) begin
                doStatus = writeEnableLatch_ff & ~pinGuardActive;
            end else if (opcode_ff == OP_PAGE_WIPE && bitCnt_ff == BITS_ADDR_CMD) begin
                doPage = writeEnableLatch_ff
                       & ~addrGuarded(blockGuard_ff, cmdAddr);
            end else if (opcode_ff == OP_SECTOR_WIPE && bitCnt_ff == BITS_ADDR_CMD) begin
                doSector = writeEnableLatch_ff
                         & ~addrGuarded(blockGuard_ff, cmdAddr);
            end else if (opcode_ff == OP_CHIP_WIPE && bitCnt_ff == BITS_OPCODE) begin
                doChip = writeEnableLatch_ff & (blockGuard_ff == 2'h0);
            end else if (opcode_ff == OP_DEEP_SLEEP && bitCnt_ff == BITS_OPCODE) begin
                doSleep = 1'b1;
            end
        end
    end

    // serial front end: opcode then body bits, counted on sck rises
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_IDLE;
            bitCnt_ff <= 6'h00;
            opcode_ff <= 8'h00;
            shiftIn_ff <= '0;
        end else if (csSync) begin
            state_ff <= ST_IDLE;
            bitCnt_ff <= 6'h00;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (csFall) begin
                        state_ff <= ST_OPCODE;
                    end
                end
                ST_OPCODE: begin
                    if (sckRise) begin
                        opcode_ff <= {opcode_ff[6:0], siSync};
                        bitCnt_ff <= bitCnt_ff + 6'h01;
                        if (bitCnt_ff == BITS_OPCODE - 6'h01) begin
                            state_ff <= ST_BODY;
                        end
                    end
                end
                ST_BODY: begin
                    if (sckRise) begin
                        shiftIn_ff <= {shiftIn_ff[CNT_W-2:0], siSync};
                        if (bitCnt_ff != 6'h3f) begin
                            bitCnt_ff <= bitCnt_ff + 6'h01;
                        end
                        if (opcode_ff == OP_WAKE_SIG
                            && bitCnt_ff == BITS_ADDR_CMD - 6'h01) begin
                            state_ff <= ST_SIGNATURE;
                        end else if (sleep_ff && opcode_ff != OP_WAKE_SIG) begin
                            state_ff <= ST_IGNORE;
                        end
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // signature shifter: msb first, repeats until deselect
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sigBit_ff <= 3'h7;
            serialOut <= 1'b0;
            serialOutEnN <= 1'b1;
        end else if (state_ff != ST_SIGNATURE || csSync) begin
            sigBit_ff <= 3'h7;
            serialOutEnN <= 1'b1;
        end else if (sckFall) begin
            serialOut <= SIGNATURE[sigBit_ff];
            serialOutEnN <= 1'b0;
            sigBit_ff <= sigBit_ff - 3'h1;
        end
    end

    // write-enable latch
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            writeEnableLatch_ff <= 1'b0;
        end else if (doUnlock) begin
            writeEnableLatch_ff <= 1'b1;
        end else if (doLock || doStatus || doPage || doSector || doChip) begin
            writeEnableLatch_ff <= 1'b0;
        end
    end

    // nonvolatile status bits; the stored write data is committed at once
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pinGuardEnable_ff <= NV_RESET[2];
            blockGuard_ff <= NV_RESET[1:0];
        end else if (doStatus) begin
            pinGuardEnable_ff <= shiftIn_ff[SR_PIN_GUARD];
            blockGuard_ff <= {shiftIn_ff[SR_GUARD_HIGH], shiftIn_ff[SR_GUARD_LOW]};
        end
    end

    // self-timed cycle; requests arriving while busy are dropped above
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            busyState_ff <= BZ_IDLE;
            busy_ff <= 1'b0;
            busyCnt_ff <= '0;
            wipeStart <= 1'b0;
            wipeKind <= KIND_PAGE;
            wipeAddr <= '0;
        end else begin
            wipeStart <= 1'b0;
            case (busyState_ff)
                BZ_IDLE: begin
                    if (doStatus || doPage || doSector || doChip) begin
                        busyState_ff <= BZ_BUSY;
                        busy_ff <= 1'b1;
                        wipeStart <= ~doStatus;
                        if (doPage) begin
                            wipeKind <= KIND_PAGE;
                            wipeAddr <= {cmdAddr[ADDR_W-1:PAGE_BITS], {PAGE_BITS{1'b0}}};
                            busyCnt_ff <= CNT_W'(PAGE_CYCLES - 1);
                        end else if (doSector) begin
                            wipeKind <= KIND_SECTOR;
                            wipeAddr <= {cmdAddr[ADDR_W-1:ADDR_W-2], {(ADDR_W-2){1'b0}}};
                            busyCnt_ff <= CNT_W'(SECTOR_CYCLES - 1);
                        end else if (doChip) begin
                            wipeKind <= KIND_CHIP;
                            wipeAddr <= '0;
                            busyCnt_ff <= CNT_W'(CHIP_CYCLES - 1);
                        end else begin
                            wipeKind <= KIND_STATUS;
                            busyCnt_ff <= CNT_W'(STATUS_CYCLES - 1);
                        end
                    end
                end
                BZ_BUSY: begin
                    // deselect or new traffic cannot disturb the count
                    if (busyCnt_ff == '0) begin
                        busyState_ff <= BZ_IDLE;
                        busy_ff <= 1'b0;
                    end else begin
                        busyCnt_ff <= busyCnt_ff - CNT_W'(1);
                    end
                end
                default: begin
                    busyState_ff <= BZ_IDLE;
                end
            endcase
        end
    end

    // deep sleep: entered on exact deselect, left after the wake delay once a wake selection of 8 or more bits deselects
    logic wakeSeen;
    assign wakeSeen = sleep_ff && csRise && opcode_ff == OP_WAKE_SIG
                    && bitCnt_ff >= BITS_OPCODE;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sleep_ff <= 1'b0;
            sleepCnt_ff <= '0;
            wakePending_ff <= 1'b0;
            sleepSettled <= 1'b0;
        end else if (doSleep) begin
            sleep_ff <= 1'b1;
            sleepCnt_ff <= CNT_W'(SETTLE_CYCLES - 1);
            sleepSettled <= 1'b0;
        end else if (wakeSeen) begin
            wakePending_ff <= 1'b1;
            sleepSettled <= 1'b0;
            sleepCnt_ff <= CNT_W'(WAKE_CYCLES - 1);
        end else if (sleepCnt_ff != '0) begin
            sleepCnt_ff <= sleepCnt_ff - CNT_W'(1);
        end else if (wakePending_ff) begin
            wakePending_ff <= 1'b0;
            sleep_ff <= 1'b0;
        end else if (sleep_ff) begin
            sleepSettled <= 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            statusReg <= 8'h00;
            inDeepSleep <= 1'b0;
        end else begin
            statusReg <= 8'h00;
            statusReg[SR_PIN_GUARD] <= pinGuardEnable_ff;
            statusReg[SR_GUARD_HIGH] <= blockGuard_ff[1];
            statusReg[SR_GUARD_LOW] <= blockGuard_ff[0];
            statusReg[SR_WEL] <= writeEnableLatch_ff;
            statusReg[SR_WIP] <= busy_ff;
            inDeepSleep <= sleep_ff;
        end
    end
endmodule : eeprom_protect_erase_powerdown
`default_nettype wire

// ---- eeprom_cmd_monitor.sv ----
/* checker for the eeprom command block: start pulses, guards, sleep.
   assumes it is bound to the block's top-level ports. */
`timescale 1ns/1ps
`default_nettype none
module eeprom_cmd_monitor
    import eeprom_cmd_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic chipSelN,
    input wire logic writeGuardN,
    input wire logic serialOutEnN,
    input wire logic [7:0] statusReg,
    input wire logic inDeepSleep,
    input wire logic sleepSettled,
    input wire logic wipeStart,
    input wire logic [1:0] wipeKind,
    input wire logic [ADDR_W-1:0] wipeAddr
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    logic [1:0] bp;
    assign bp = statusReg[3:2];
    a_power_up_clear: assert property (
        $rose(rst_n) |-> statusReg == 8'h00 && serialOutEnN && !inDeepSleep)
        else $error("state not clear after reset");
    a_deselect_off: assert property (
        chipSelN [*6] |-> serialOutEnN) else $error("output driven while deselected");
    a_start_latched: assert property (
        wipeStart |-> statusReg[1] && !statusReg[0]) else $error("start without latch or busy");
    a_start_busy: assert property (
        wipeStart |-> ##[1:3] statusReg[0]) else $error("busy flag missing after start");
    a_start_pulse: assert property (
        wipeStart |=> !wipeStart) else $error("start pulse too long");
    a_chip_unguarded: assert property (
        wipeStart && wipeKind == 2'h2 |-> bp == 2'h0 && wipeAddr == 17'h00000)
        else $error("chip wipe under block guard");
    a_region_free: assert property (
        wipeStart && !wipeKind[1] |-> !(bp == 2'h3 || (bp == 2'h2 && wipeAddr[16])
        || (bp == 2'h1 && wipeAddr[16:15] == 2'h3))) else $error("guarded region wiped");
    a_base_aligned: assert property (
        wipeStart && !wipeKind[1] |-> (wipeKind[0] ? wipeAddr[14:0] == 15'h0000
        : wipeAddr[7:0] == 8'h00)) else $error("wipe base not aligned");
    // pin is seen through two flops, so the image lags it by four clocks
    a_pin_guard: assert property (
        $changed(statusReg[7:2]) |-> !$past(statusReg[7]) || $past(writeGuardN, 4))
        else $error("status write under pin guard");
    a_latch_after: assert property (
        $fell(statusReg[0]) |-> !statusReg[1]) else $error("latch kept after cycle");
    a_sleep_quiet: assert property (
        inDeepSleep |-> !wipeStart) else $error("wipe started while asleep");
    a_settle_in_sleep: assert property (
        sleepSettled |-> inDeepSleep) else $error("settled while awake");
    a_settle_delay: assert property (
        $rose(inDeepSleep) |-> !sleepSettled [*3]) else $error("settled too early");
    c_chip_wipe: cover property (wipeStart && wipeKind == 2'h2);
    c_sector_wipe: cover property (wipeStart && wipeKind == 2'h1);
    c_wake: cover property ($fell(inDeepSleep));
endmodule : eeprom_cmd_monitor
bind eeprom_protect_erase_powerdown eeprom_cmd_monitor eeprom_cmd_monitor_i (
    .clock(clock), .rst_n(rst_n), .chipSelN(chipSelN), .writeGuardN(writeGuardN),
    .serialOutEnN(serialOutEnN), .statusReg(statusReg), .inDeepSleep(inDeepSleep),
    .sleepSettled(sleepSettled), .wipeStart(wipeStart), .wipeKind(wipeKind),
    .wipeAddr(wipeAddr));
`default_nettype wire

// ---- eeprom_host_model.sv ----
/* host side of the serial bus: frames bits msb first, collects returns.
   assumes callers enter its task at a falling edge of clock. */
`timescale 1ns/1ps
`default_nettype none
module eeprom_host_model (
    input wire logic clock,
    input wire logic serialOut,
    output logic chipSelN,
    output logic serialClk,
    output logic serialIn,
    output logic [47:0] rxBits
);
    initial begin
        chipSelN = 1'b1;
        serialClk = 1'b0;
        serialIn = 1'b0;
        rxBits = 48'h0;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask : tick
    task automatic xfer(input logic [47:0] frame, input int n);
        chipSelN = 1'b0;
        tick(4);
        for (int i = 0; i < n; i++) begin
            serialIn = frame[47 - i];
            tick(4);
            serialClk = 1'b1;
            rxBits = {rxBits[46:0], serialOut};
            tick(4);
            serialClk = 1'b0;
        end
        tick(4);
        chipSelN = 1'b1;
        // idle data line must not keep the last bit
        serialIn = ~serialIn;
        tick(8);
    endtask : xfer
endmodule : eeprom_host_model
`default_nettype wire

// ---- eeprom_protect_erase_powerdown_tb_top.sv ----
/* self-checking bench: host model drives commands, a reference model
   predicts starts and status. assumes shortened cycle parameters. */
`timescale 1ns/1ps
`default_nettype none
module eeprom_protect_erase_powerdown_tb_top
    import eeprom_cmd_pkg::*;
();
    localparam logic [7:0] SIG = 8'h3c;  // arbitrary value
    localparam int WAKE = CYC_WAKE;
    logic clock, rst_n, writeGuardN, chipSelN, serialClk, serialIn, serialOut;
    logic serialOutEnN, inDeepSleep, sleepSettled, wipeStart;
    logic [7:0] statusReg;
    logic [1:0] wipeKind, kindSeen;
    logic [16:0] wipeAddr, addrSeen;
    logic [47:0] rxBits;
    int err_count = 0, comparisons = 0, starts = 0, cycles = 0;
    int latch = 0, bp = 0, pen = 0, sleep = 0;
    // settle and wake keep their default lengths; only the long cycles shrink
    eeprom_protect_erase_powerdown #(.STATUS_CYCLES(20), .PAGE_CYCLES(20),
        .SECTOR_CYCLES(30), .CHIP_CYCLES(30),
        .SIGNATURE(SIG)) eeprom_protect_erase_powerdown_i (.clock(clock), .rst_n(rst_n),
        .chipSelN(chipSelN), .serialClk(serialClk), .serialIn(serialIn),
        .writeGuardN(writeGuardN), .serialOut(serialOut), .serialOutEnN(serialOutEnN),
        .statusReg(statusReg), .inDeepSleep(inDeepSleep), .sleepSettled(sleepSettled),
        .wipeStart(wipeStart), .wipeKind(wipeKind), .wipeAddr(wipeAddr));
    eeprom_host_model eeprom_host_model_i (.clock(clock), .serialOut(serialOut),
        .chipSelN(chipSelN), .serialClk(serialClk), .serialIn(serialIn), .rxBits(rxBits));
    always #50 clock = ~clock;
    // sampled mid-cycle, away from the edge that launches the pulse
    always @(negedge clock) begin
        if (wipeStart === 1'b1) begin
            starts++;
            kindSeen = wipeKind;
            addrSeen = wipeAddr;
        end
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 80000) begin
            err_count++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    function automatic bit prot(input logic [16:0] a);
        return bp == 3 || (bp == 2 && a >= 17'h10000) || (bp == 1 && a >= 17'h18000);
    endfunction : prot
    task automatic run(input logic [7:0] op, input logic [23:0] arg, input int n);
        int go;
        int k;
        logic [16:0] a;
        go = 0;
        k = 0;
        a = arg[16:0];
        if (sleep == 0 || op == OP_WAKE_SIG) begin
            if (op == OP_WRITE_UNLOCK && n == 8) latch = 1;
            if (op == OP_WRITE_LOCK && n == 8) latch = 0;
            if (op == OP_DEEP_SLEEP && n == 8) sleep = 1;
            if (op == OP_WAKE_SIG && n >= 8) sleep = 0;
            if (latch && op == OP_STATUS_WRITE && n == 16 && !(pen && !writeGuardN)) k = 3;
            if (latch && op == OP_PAGE_WIPE && n == 32 && !prot(a)) k = 4;
            if (latch && op == OP_SECTOR_WIPE && n == 32 && !prot(a)) k = 5;
            if (latch && op == OP_CHIP_WIPE && n == 8 && bp == 0) k = 6;
        end
        go = k != 0;
        k = k & 3;
        a = (k == 0) ? (a & 17'h1ff00) : (k == 1) ? (a & 17'h18000) : 17'h00000;
        starts = 0;
        eeprom_host_model_i.xfer({op, arg, 16'h0}, n);
        eeprom_host_model_i.tick(4);
        // a status write runs a busy cycle but sends no start to the array
        check("start count", starts, go && k != 3);
        if (go) check("kind", (k == 3) ? wipeKind : kindSeen, k);
        if (go && k != 3) check("base", addrSeen, a);
        if (go && k == 3) begin
            pen = arg[23];
            bp = arg[19:18];
        end
        if (go) latch = 0;
        for (int w = 0; w < 200 && statusReg[0] !== 1'b0; w++) eeprom_host_model_i.tick(1);
        check("status", statusReg, {pen[0], 3'h0, bp[1:0], latch[0], 1'b0});
    endtask : run
    task automatic set_guard(input logic [23:0] arg);
        run(OP_WRITE_UNLOCK, 24'h0, 8);
        run(OP_STATUS_WRITE, arg, 16);
    endtask : set_guard
    initial begin
        clock = 1'b0;
        rst_n = 1'b0;
        writeGuardN = 1'b1;
        void'($urandom(43));
        repeat (2) @(posedge clock);
        @(negedge clock);
        rst_n = 1'b1;
        eeprom_host_model_i.tick(4);
        check("power-up status", statusReg, 8'h00);
        check("output off", serialOutEnN, 1'b1);
        for (int b = 0; b < 4; b++) begin
            set_guard({4'h0, b[1:0], 18'h0});
            for (int t = 0; t < 6; t++) begin
                run(OP_WRITE_UNLOCK, 24'h0, 8);
                run(t < 4 ? OP_PAGE_WIPE : OP_SECTOR_WIPE,
                    {7'h0, t[1:0], 15'($urandom)}, 32);
            end
            run(OP_WRITE_UNLOCK, 24'h0, 8);
            run(OP_CHIP_WIPE, 24'h0, 8);
        end
        set_guard(24'h0);
        run(OP_WRITE_LOCK, 24'h0, 8);
        run(OP_CHIP_WIPE, 24'h0, 8);
        run(OP_WRITE_UNLOCK, 24'h0, 8);
        run(OP_PAGE_WIPE, 24'h001234, 31);
        run(OP_SECTOR_WIPE, 24'h001234, 33);
        run(OP_CHIP_WIPE, 24'h0, 9);
        run(OP_STATUS_WRITE, 24'h080000, 15);
        set_guard(24'h800000);
        writeGuardN = 1'b0;
        set_guard(24'h840000);
        run(OP_PAGE_WIPE, {8'h0, 16'($urandom)}, 32);
        writeGuardN = 1'b1;
        set_guard(24'h000000);
        writeGuardN = 1'b0;
        set_guard(24'h080000);
        set_guard(24'h000000);
        writeGuardN = 1'b1;
        run(OP_DEEP_SLEEP, 24'h0, 9);
        check("sleep on wrong count", inDeepSleep, 1'b0);
        run(OP_DEEP_SLEEP, 24'h0, 8);
        check("sleep", inDeepSleep, 1'b1);
        eeprom_host_model_i.tick(30);
        check("settled", sleepSettled, 1'b1);
        run(OP_WRITE_UNLOCK, 24'h0, 8);
        run(OP_WAKE_SIG, 24'($urandom), 48);
        check("signature", rxBits[15:0], {SIG, SIG});
        eeprom_host_model_i.tick(WAKE + 10);
        check("awake", inDeepSleep, 1'b0);
        run(OP_DEEP_SLEEP, 24'h0, 8);
        rst_n = 1'b0;
        eeprom_host_model_i.tick(2);
        rst_n = 1'b1;
        sleep = 0;
        eeprom_host_model_i.tick(4);
        check("sleep after power cycle", inDeepSleep, 1'b0);
        check("status after power cycle", statusReg, 8'h00);
        finish_test();
    end
endmodule : eeprom_protect_erase_powerdown_tb_top
`default_nettype wire
